//--- pkg/sura_pkg.sv
package sura_pkg;
	localparam int CLK_HZ   = 50_000_000;
	localparam int CLK_MHZ  = 50;
	localparam int DG_BITS  = 40;
	localparam int DG_BYTES = 5;
	localparam int RT_WORDS = 4;
	localparam int REPLY_BYTES = DG_BYTES + 4 * RT_WORDS;

	localparam logic [6:0] ADDR_INFO     = 7'h00;
	localparam logic [6:0] ADDR_INFO_SEL = 7'h01;
	localparam logic [6:0] ADDR_BAUD     = 7'h79;
	localparam logic [6:0] ADDR_RT_BURST = 7'h7f;
	localparam logic [31:0] INFO_SEL_TYPE    = 32'h0000_0000;
	localparam logic [31:0] INFO_SEL_VERSION = 32'h0000_0001;

	localparam logic [31:0] BAUD_9600   = 32'h0000_9600;
	localparam logic [31:0] BAUD_115200 = 32'h0011_5200;
	localparam logic [31:0] BAUD_921600 = 32'h0092_1600;
	localparam logic [31:0] BAUD_3M     = 32'h0300_0000;
	localparam logic [31:0] BAUD_RESET  = BAUD_9600;
	localparam int DIV_9600   = (CLK_HZ + 4800) / 9600;
	localparam int DIV_115200 = (CLK_HZ + 57600) / 115200;
	localparam int DIV_921600 = (CLK_HZ + 460800) / 921600;
	localparam int DIV_3M     = (CLK_HZ + 1500000) / 3000000;

	localparam int TIMEOUT_S   = 1;
	localparam int PAUSE_NS    = 500;
	localparam int PAUSE_CYC   = (PAUSE_NS * CLK_MHZ + 999) / 1000;
	localparam int HOST_SCK_HZ = 5_000_000;
	localparam int SCK_HALF_CYC = CLK_HZ / (2 * HOST_SCK_HZ);

	localparam logic [2:0] H_TXHI    = 3'h0;
	localparam logic [2:0] H_TXDATA  = 3'h1;
	localparam logic [2:0] H_CTRL    = 3'h2;
	localparam logic [2:0] H_SPIRX   = 3'h3;
	localparam logic [2:0] H_UARTRX  = 3'h4;
	localparam logic [2:0] H_UARTHI  = 3'h5;
	localparam int CTRL_SPI_GO   = 0;
	localparam int CTRL_UART_GO  = 1;
	localparam int ST_SPI_DONE   = 2;
	localparam int ST_UART_DONE  = 3;

	typedef enum logic [1:0] {
		URX_IDLE  = 2'b00,
		URX_START = 2'b01,
		URX_DATA  = 2'b11,
		URX_STOP  = 2'b10
	} sura_urx_e;

	typedef enum logic [1:0] {
		SPI_IDLE  = 2'b00,
		SPI_SHIFT = 2'b01,
		SPI_PAUSE = 2'b11,
		SPI_TAIL  = 2'b10
	} sura_spi_e;
endpackage : sura_pkg

//--- pkg/sura_if.sv
`timescale 1ns/1ps
interface sura_if;
	logic sck;
	logic chipSelectN;
	logic mosi;
	logic misoOut;
	logic misoOe;
	logic miso;
	logic hostTxd;
	logic devTxd;

	// The serial-out line is pulled high while nobody drives it.
	assign miso = misoOe ? misoOut : 1'b1;

	modport dev (
		input  sck,
		input  chipSelectN,
		input  mosi,
		input  hostTxd,
		output misoOut,
		output misoOe,
		output devTxd
	);
	modport host (
		output sck,
		output chipSelectN,
		output mosi,
		output hostTxd,
		input  miso,
		input  devTxd
	);
endinterface : sura_if

//--- rtl/sura_device.sv
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
module sura_device
	import sura_pkg::*;
#(
	parameter logic [31:0] CHIP_TYPE    = 32'h5355_5241, // Arbitrary value.
	parameter logic [31:0] CHIP_VERSION = 32'h0000_0100, // Arbitrary value.
	parameter int          TIMEOUT_CYC  = TIMEOUT_S * CLK_HZ,
	parameter int          DIV_9600_CYC = DIV_9600
) (
	input  wire logic                   core_clk,
	input  wire logic                   sys_rst,
	input  wire logic [RT_WORDS*32-1:0] rtData,
	sura_if.dev                         link
);

	logic [31:0]              bank [128];
	logic [5:0]               bitCnt;
	logic [39:0]              shIn;
	logic [7:0]               addrByte;
	logic [39:0]              frameWord;
	logic                     addrTog;
	logic                     wrTog;
	logic [31:0]              outSh;
	logic                     misoBit;
	logic [31:0]              rdWord;
	logic [2:0]               s1;
	logic [2:0]               s2;
	logic [2:0]               s3;
	logic [2:0]               acc;
	logic                     spiAddrEv;
	logic                     spiWrEv;
	logic                     rxdLvl;
	logic [15:0]              divNow;
	sura_urx_e                rxSt;
	logic [15:0]              rxCnt;
	logic [2:0]               rxBit;
	logic [7:0]               rxSh;
	logic                     rxValid;
	logic [2:0]               byteIdx;
	logic [31:0]              toCnt;
	logic [31:0]              rxFrame;
	logic                     uWrPend;
	logic [6:0]               uWrAddr;
	logic [31:0]              uWrData;
	logic                     loadReq;
	logic [REPLY_BYTES*8-1:0] loadBuf;
	logic [4:0]               loadLen;
	logic [REPLY_BYTES*8-1:0] replyBuf;
	logic [4:0]               txRemain;
	logic [9:0]               txFrame;
	logic                     txBusy;
	logic [3:0]               txBit;
	logic [15:0]              txCnt;

	function automatic logic [31:0] bankRead(input logic [6:0] a);
		if (a == ADDR_INFO) begin
			case (bank[ADDR_INFO_SEL])
				INFO_SEL_TYPE:    bankRead = CHIP_TYPE;
				INFO_SEL_VERSION: bankRead = CHIP_VERSION;
				default:          bankRead = '0;
			endcase
		end else begin
			bankRead = bank[a];
		end
	endfunction : bankRead

	function automatic logic [15:0] baudDiv(input logic [31:0] code);
		case (code)
			BAUD_115200: baudDiv = 16'(DIV_115200);
			BAUD_921600: baudDiv = 16'(DIV_921600);
			BAUD_3M:     baudDiv = 16'(DIV_3M);
			default:     baudDiv = 16'(DIV_9600_CYC);
		endcase
	endfunction : baudDiv

	////////////////////////////////////////////////////////////////////////
	// Link clock domain. The chip select clears the frame state, since
	// the clock stands still between frames.

	always_ff @(posedge link.sck or posedge link.chipSelectN) begin
		if (link.chipSelectN) begin
			bitCnt <= '0;
			shIn   <= '0;
		end else begin
			shIn <= {shIn[38:0], link.mosi};
			if (bitCnt != 6'(DG_BITS))
				bitCnt <= bitCnt + 6'd1;
		end
	end

	always_ff @(posedge link.sck or posedge sys_rst) begin
		if (sys_rst) begin
			addrByte  <= '0;
			addrTog   <= 1'b0;
			frameWord <= '0;
			wrTog     <= 1'b0;
		end else if (!link.chipSelectN) begin
			if (bitCnt == 6'd7) begin
				addrByte <= {shIn[6:0], link.mosi};
				addrTog  <= ~addrTog;
			end
			if (bitCnt == 6'(DG_BITS - 1)) begin
				frameWord <= {shIn[38:0], link.mosi};
				if (shIn[38])
					wrTog <= ~wrTog;
			end
		end
	end

	// The read word is taken from the core domain without a crossing:
	// the master holds the clock still after the address byte of a read, so it is
	// settled by the first data edge. Fast reads without that pause fail.
	always_ff @(negedge link.sck or posedge link.chipSelectN) begin
		if (link.chipSelectN) begin
			outSh   <= '0;
			misoBit <= 1'b0;
		end else if (bitCnt == 6'd8) begin
			misoBit <= rdWord[31];
			outSh   <= {rdWord[30:0], 1'b0};
		end else begin
			misoBit <= outSh[31];
			outSh   <= {outSh[30:0], 1'b0};
		end
	end

	assign link.misoOut = misoBit;
	assign link.misoOe  = !link.chipSelectN;

	////////////////////////////////////////////////////////////////////////
	// Crossings into the core clock.

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s1  <= 3'b100;
			s2  <= 3'b100;
			s3  <= 3'b100;
			acc <= 3'b100;
		end else begin
			s1 <= {link.hostTxd, wrTog, addrTog};
			s2 <= s1;
			s3 <= s2;
			for (int i = 0; i < 3; i++) begin
				if (s2[i] == s3[i])
					acc[i] <= s3[i];
			end
		end
	end

	assign spiAddrEv = (s2[0] == s3[0]) && (s3[0] != acc[0]);
	assign spiWrEv   = (s2[1] == s3[1]) && (s3[1] != acc[1]);
	assign rxdLvl    = acc[2];

	////////////////////////////////////////////////////////////////////////
	// Register bank.

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < 128; i++)
				bank[i] <= (i == int'(ADDR_BAUD)) ? BAUD_RESET : '0;
		end else if (spiWrEv) begin
			if (frameWord[38:32] != ADDR_INFO)
				bank[frameWord[38:32]] <= frameWord[31:0];
		end else if (uWrPend) begin
			if (uWrAddr != ADDR_INFO)
				bank[uWrAddr] <= uWrData;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			rdWord <= '0;
		else if (spiAddrEv)
			rdWord <= bankRead(addrByte[6:0]);
	end

	assign divNow = baudDiv(bank[ADDR_BAUD]);

	////////////////////////////////////////////////////////////////////////
	// Serial receiver.

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rxSt    <= URX_IDLE;
			rxCnt   <= '0;
			rxBit   <= '0;
			rxSh    <= '0;
			rxValid <= 1'b0;
		end else begin
			rxValid <= 1'b0;
			case (rxSt)
				URX_IDLE: begin
					rxCnt <= divNow >> 1;
					if (!rxdLvl)
						rxSt <= URX_START;
				end
				URX_START: begin
					if (rxCnt != 16'h0000) begin
						rxCnt <= rxCnt - 16'h0001;
					end else if (!rxdLvl) begin
						rxSt  <= URX_DATA;
						rxCnt <= divNow - 16'h0001;
						rxBit <= '0;
					end else begin
						rxSt <= URX_IDLE;
					end
				end
				URX_DATA: begin
					if (rxCnt != 16'h0000) begin
						rxCnt <= rxCnt - 16'h0001;
					end else begin
						rxSh  <= {rxdLvl, rxSh[7:1]};
						rxCnt <= divNow - 16'h0001;
						rxBit <= rxBit + 3'd1;
						if (rxBit == 3'd7)
							rxSt <= URX_STOP;
					end
				end
				URX_STOP: begin
					if (rxCnt != 16'h0000) begin
						rxCnt <= rxCnt - 16'h0001;
					end else begin
						rxSt    <= URX_IDLE;
						rxValid <= rxdLvl;
					end
				end
				default: rxSt <= URX_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Datagram assembly, timeout and replies.

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			byteIdx <= '0;
			toCnt   <= '0;
			rxFrame <= '0;
			uWrPend <= 1'b0;
			uWrAddr <= '0;
			uWrData <= '0;
			loadReq <= 1'b0;
			loadBuf <= '0;
			loadLen <= '0;
		end else begin
			loadReq <= 1'b0;
			if (uWrPend && !spiWrEv) begin
				uWrPend <= 1'b0;
				loadReq <= 1'b1;
				loadBuf <= {1'b1, uWrAddr, uWrData, {RT_WORDS*32{1'b0}}};
				loadLen <= 5'(DG_BYTES);
			end
			if (rxValid) begin
				toCnt   <= '0;
				rxFrame <= {rxFrame[23:0], rxSh};
				if (byteIdx == 3'(DG_BYTES - 1)) begin
					byteIdx <= '0;
					if (rxFrame[31]) begin
						uWrPend <= 1'b1;
						uWrAddr <= rxFrame[30:24];
						uWrData <= {rxFrame[23:0], rxSh};
					end else if (rxFrame[30:24] == ADDR_RT_BURST) begin
						loadReq <= 1'b1;
						loadBuf <= {rxFrame[31:24], bankRead(rxFrame[30:24]),
							rtData};
						loadLen <= 5'(REPLY_BYTES);
					end else begin
						loadReq <= 1'b1;
						loadBuf <= {rxFrame[31:24], bankRead(rxFrame[30:24]),
							{RT_WORDS*32{1'b0}}};
						loadLen <= 5'(DG_BYTES);
					end
				end else begin
					byteIdx <= byteIdx + 3'd1;
				end
			end else if (byteIdx != 3'd0) begin
				if (toCnt == 32'(TIMEOUT_CYC - 1)) begin
					byteIdx <= '0;
					toCnt   <= '0;
				end else begin
					toCnt <= toCnt + 32'd1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Serial transmitter. A new reply replaces whatever is left unsent.

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			replyBuf <= '0;
			txRemain <= '0;
			txFrame  <= '1;
			txBusy   <= 1'b0;
			txBit    <= '0;
			txCnt    <= '0;
		end else begin
			if (loadReq) begin
				replyBuf <= loadBuf;
				txRemain <= loadLen;
			end else if (!txBusy && txRemain != 5'd0) begin
				replyBuf <= replyBuf << 8;
				txRemain <= txRemain - 5'd1;
			end
			if (!txBusy && txRemain != 5'd0 && !loadReq) begin
				txFrame <= {1'b1, replyBuf[REPLY_BYTES*8-1 -: 8], 1'b0};
				txBusy  <= 1'b1;
				txBit   <= '0;
				txCnt   <= divNow - 16'h0001;
			end else if (txBusy) begin
				if (txCnt != 16'h0000) begin
					txCnt <= txCnt - 16'h0001;
				end else begin
					txFrame <= {1'b1, txFrame[9:1]};
					txCnt   <= divNow - 16'h0001;
					txBit   <= txBit + 4'd1;
					if (txBit == 4'd9)
						txBusy <= 1'b0;
				end
			end
		end
	end

	assign link.devTxd = txFrame[0];

endmodule : sura_device

//--- rtl/sura_host.sv
`timescale 1ns/1ps
module sura_host
	import sura_pkg::*;
#(
	parameter int HOST_BAUD_CYC = DIV_9600
) (
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	input  wire logic [2:0]  regAddr,
	input  wire logic [31:0] regWrData,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [31:0] regRdData,
	sura_if.host             link
);

	logic [7:0]  txHi;
	logic [31:0] txData;
	logic        spiPend;
	logic        uartPend;
	logic        spiDone;
	logic        uartDone;
	logic [31:0] spiRx;
	logic [39:0] uartRx;
	logic        ctrlWr;
	logic        spiStart;
	logic        spiFin;
	logic        uartStart;
	logic        uartFin;
	logic [1:0]  s1;
	logic [1:0]  s2;
	logic [1:0]  s3;
	logic [1:0]  acc;
	sura_spi_e   spiSt;
	logic [7:0]  divCnt;
	logic [5:0]  bitIdx;
	logic [39:0] shOut;
	logic [39:0] shIn;
	logic        sckReg;
	logic        csReg;
	logic        mosiReg;
	logic [39:0] uTxBuf;
	logic [2:0]  uTxRemain;
	logic [9:0]  uTxFrame;
	logic        uTxBusy;
	logic [3:0]  uTxBit;
	logic [15:0] uTxCnt;
	sura_urx_e   rxSt;
	logic [15:0] rxCnt;
	logic [2:0]  rxBit;
	logic [7:0]  rxSh;
	logic [2:0]  rxIdx;
	logic [39:0] rxAcc;
	logic [31:0] rdMux;

	assign ctrlWr    = regWr && (regAddr == H_CTRL);
	assign spiStart  = spiPend && (spiSt == SPI_IDLE) && (divCnt == 8'h00);
	assign uartStart = uartPend && !uTxBusy && (uTxRemain == 3'd0);

	////////////////////////////////////////////////////////////////////////
	// Command and status registers. Done flags: a set beats a clear.

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			txHi     <= '0;
			txData   <= '0;
			spiPend  <= 1'b0;
			uartPend <= 1'b0;
			spiDone  <= 1'b0;
			uartDone <= 1'b0;
		end else begin
			if (regWr && regAddr == H_TXHI)
				txHi <= regWrData[7:0];
			if (regWr && regAddr == H_TXDATA)
				txData <= regWrData;
			spiPend  <= (ctrlWr && regWrData[CTRL_SPI_GO]) ||
				(spiPend && !spiStart);
			uartPend <= (ctrlWr && regWrData[CTRL_UART_GO]) ||
				(uartPend && !uartStart);
			spiDone  <= spiFin ||
				(spiDone && !(ctrlWr && regWrData[ST_SPI_DONE]));
			uartDone <= uartFin ||
				(uartDone && !(ctrlWr && regWrData[ST_UART_DONE]));
		end
	end

	always_comb begin
		case (regAddr)
			H_TXHI:   rdMux = {24'h000000, txHi};
			H_TXDATA: rdMux = txData;
			H_CTRL:   rdMux = {28'h0000000, uartDone, spiDone,
				uartPend || uTxBusy || (uTxRemain != 3'd0),
				spiPend || (spiSt != SPI_IDLE)};
			H_SPIRX:  rdMux = spiRx;
			H_UARTRX: rdMux = uartRx[31:0];
			H_UARTHI: rdMux = {24'h000000, uartRx[39:32]};
			default:  rdMux = '0;
		endcase
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			regRdData <= '0;
		else
			regRdData <= regRd ? rdMux : '0;
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s1  <= 2'b11;
			s2  <= 2'b11;
			s3  <= 2'b11;
			acc <= 2'b11;
		end else begin
			s1 <= {link.devTxd, link.miso};
			s2 <= s1;
			s3 <= s2;
			for (int i = 0; i < 2; i++) begin
				if (s2[i] == s3[i])
					acc[i] <= s3[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Serial master. The clock is divided from the core clock.

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			spiSt   <= SPI_IDLE;
			divCnt  <= '0;
			bitIdx  <= '0;
			shOut   <= '0;
			shIn    <= '0;
			sckReg  <= 1'b1;
			csReg   <= 1'b1;
			mosiReg <= 1'b1;
			spiRx   <= '0;
			spiFin  <= 1'b0;
		end else begin
			spiFin <= 1'b0;
			case (spiSt)
				SPI_IDLE: begin
					if (divCnt != 8'h00) begin
						divCnt <= divCnt - 8'h01;
					end else if (spiPend) begin
						csReg  <= 1'b0;
						shOut  <= {txHi, txData};
						bitIdx <= '0;
						divCnt <= 8'(SCK_HALF_CYC - 1);
						spiSt  <= SPI_SHIFT;
					end
				end
				SPI_SHIFT: begin
					if (divCnt != 8'h00) begin
						divCnt <= divCnt - 8'h01;
					end else if (sckReg) begin
						sckReg  <= 1'b0;
						mosiReg <= shOut[39];
						shOut   <= {shOut[38:0], 1'b0};
						divCnt  <= 8'(SCK_HALF_CYC - 1);
					end else begin
						sckReg <= 1'b1;
						shIn   <= {shIn[38:0], acc[0]};
						bitIdx <= bitIdx + 6'd1;
						divCnt <= 8'(SCK_HALF_CYC - 1);
						if (bitIdx == 6'd7 && !txHi[7]) begin
							divCnt <= 8'(PAUSE_CYC - 1);
							spiSt  <= SPI_PAUSE;
						end else if (bitIdx == 6'(DG_BITS - 1)) begin
							spiSt <= SPI_TAIL;
						end
					end
				end
				SPI_PAUSE: begin
					if (divCnt != 8'h00)
						divCnt <= divCnt - 8'h01;
					else
						spiSt <= SPI_SHIFT;
				end
				SPI_TAIL: begin
					if (divCnt != 8'h00) begin
						divCnt <= divCnt - 8'h01;
					end else begin
						csReg  <= 1'b1;
						spiRx  <= shIn[31:0];
						spiFin <= 1'b1;
						divCnt <= 8'(SCK_HALF_CYC - 1);
						spiSt  <= SPI_IDLE;
					end
				end
				default: spiSt <= SPI_IDLE;
			endcase
		end
	end

	assign link.sck         = sckReg;
	assign link.chipSelectN = csReg;
	assign link.mosi        = mosiReg;

	////////////////////////////////////////////////////////////////////////
	// UART side: five bytes out, replies collected in groups of five.

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			uTxBuf    <= '0;
			uTxRemain <= '0;
			uTxFrame  <= '1;
			uTxBusy   <= 1'b0;
			uTxBit    <= '0;
			uTxCnt    <= '0;
		end else if (uartStart) begin
			uTxBuf    <= {txHi, txData};
			uTxRemain <= 3'(DG_BYTES);
		end else if (!uTxBusy && uTxRemain != 3'd0) begin
			uTxFrame  <= {1'b1, uTxBuf[39:32], 1'b0};
			uTxBuf    <= {uTxBuf[31:0], 8'h00};
			uTxRemain <= uTxRemain - 3'd1;
			uTxBusy   <= 1'b1;
			uTxBit    <= '0;
			uTxCnt    <= 16'(HOST_BAUD_CYC - 1);
		end else if (uTxBusy) begin
			if (uTxCnt != 16'h0000) begin
				uTxCnt <= uTxCnt - 16'h0001;
			end else begin
				uTxFrame <= {1'b1, uTxFrame[9:1]};
				uTxCnt   <= 16'(HOST_BAUD_CYC - 1);
				uTxBit   <= uTxBit + 4'd1;
				if (uTxBit == 4'd9)
					uTxBusy <= 1'b0;
			end
		end
	end

	assign link.hostTxd = uTxFrame[0];

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rxSt    <= URX_IDLE;
			rxCnt   <= '0;
			rxBit   <= '0;
			rxSh    <= '0;
			rxIdx   <= '0;
			rxAcc   <= '0;
			uartRx  <= '0;
			uartFin <= 1'b0;
		end else begin
			uartFin <= 1'b0;
			if (uartStart)
				rxIdx <= '0;
			if (rxCnt != 16'h0000 && rxSt != URX_IDLE) begin
				rxCnt <= rxCnt - 16'h0001;
			end else begin
				rxCnt <= 16'(HOST_BAUD_CYC - 1);
				case (rxSt)
					URX_IDLE: begin
						rxCnt <= 16'(HOST_BAUD_CYC / 2);
						if (!acc[1])
							rxSt <= URX_START;
					end
					URX_START: rxSt <= acc[1] ? URX_IDLE : URX_DATA;
					URX_DATA: begin
						rxSh  <= {acc[1], rxSh[7:1]};
						rxBit <= rxBit + 3'd1;
						if (rxBit == 3'd7)
							rxSt <= URX_STOP;
					end
					URX_STOP: begin
						rxSt <= URX_IDLE;
						if (acc[1] && !uartStart) begin
							rxAcc <= {rxAcc[31:0], rxSh};
							rxIdx <= (rxIdx == 3'(DG_BYTES - 1)) ? 3'd0 :
								rxIdx + 3'd1;
							if (rxIdx == 3'(DG_BYTES - 1)) begin
								uartRx  <= {rxAcc[31:0], rxSh};
								uartFin <= 1'b1;
							end
						end
					end
					default: rxSt <= URX_IDLE;
				endcase
			end
		end
	end

endmodule : sura_host

//--- verification/sura_props.sv
`timescale 1ns/1ps
module sura_props
	import sura_pkg::*;
#(
	parameter int BAUD_CYC = 16
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic sck,
	input wire logic chipSelectN,
	input wire logic mosi,
	input wire logic misoOut,
	input wire logic misoOe,
	input wire logic hostTxd,
	input wire logic devTxd
);
	localparam logic [11:0] STOP = 12'(9 * BAUD_CYC + BAUD_CYC / 2);
	localparam logic [11:0] LAST = 12'(10 * BAUD_CYC - 1);
	localparam logic [5:0]  PAUSE = 6'(PAUSE_CYC);
	logic [5:0]       riseCnt;
	logic [5:0]       hiCnt;
	logic             sckQ;
	logic             wrFlag;
	logic [1:0]       txdQ;
	logic [1:0][11:0] uCnt;
	wire  [1:0]       txd = {devTxd, hostTxd};
	default clocking dc @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sckQ <= 1'b1;
			hiCnt <= 6'h00;
			riseCnt <= 6'h00;
			wrFlag <= 1'b0;
		end else begin
			sckQ <= sck;
			hiCnt <= sck ? hiCnt + 6'h01 : 6'h00;
			if (chipSelectN)
				riseCnt <= 6'h00;
			else if (sck && !sckQ)
				riseCnt <= riseCnt + 6'h01;
			if (!chipSelectN && sck && !sckQ && riseCnt == 6'h00)
				wrFlag <= mosi;
		end
	end
	// The stop bit is judged mid-bit, so a divisor rounding cannot fail it.
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			txdQ <= 2'h3;
			uCnt <= '0;
		end else begin
			txdQ <= txd;
			for (int i = 0; i < 2; i++) begin
				if (uCnt[i] != 12'h000)
					uCnt[i] <= (uCnt[i] == LAST) ? 12'h000 : uCnt[i] + 12'h001;
				else if (!txd[i] && txdQ[i])
					uCnt[i] <= 12'h001;
			end
		end
	end
	sequence s_addrDone;
		$fell(sck) && !chipSelectN && riseCnt == 6'h08;
	endsequence
	sequence s_readAddr;
		s_addrDone ##0 !wrFlag;
	endsequence
	sequence s_writeAddr;
		s_addrDone ##0 wrFlag;
	endsequence
	AST_SCK_IDLE: assert property (chipSelectN |-> sck)
		else $error("clock low outside frame");
	AST_CS_EDGE: assert property (
		$changed(chipSelectN) |-> sck && $stable(sck))
		else $error("select moved with clock low");
	AST_MOSI_EDGE: assert property (
		!chipSelectN && $changed(mosi) |-> !sck)
		else $error("data out moved while clock high");
	// The address phase returns zeros, so an early read word shows up here.
	AST_MISO_EN: assert property (
		misoOe == !chipSelectN && !(misoOe && riseCnt < 6'h08 && misoOut))
		else $error("data return enable or address phase wrong");
	AST_MISO_EDGE: assert property (
		!chipSelectN && !$past(chipSelectN) && sck && $past(sck)
		|-> $stable(misoOut))
		else $error("data return moved while clock high");
	AST_FRAME_BITS: assert property (
		$rose(chipSelectN) |-> riseCnt == 6'h28)
		else $error("frame length not forty");
	AST_READ_PAUSE: assert property (s_readAddr |-> hiCnt >= PAUSE)
		else $error("read pause too short");
	AST_WRITE_FAST: assert property (s_writeAddr |-> hiCnt < PAUSE)
		else $error("write paused");
	AST_HOST_STOP: assert property (uCnt[0] == STOP |-> hostTxd)
		else $error("host stop bit low");
	AST_DEV_STOP: assert property (uCnt[1] == STOP |-> devTxd)
		else $error("device stop bit low");
endmodule : sura_props

//--- verification/tb_top.sv
`timescale 1ns/1ps
module tb_top
	import sura_pkg::*;
;
	localparam logic [31:0] TYPE_ID = 32'h1357_2468; // Arbitrary value.
	localparam logic [31:0] VER_ID  = 32'h0000_0a0b; // Arbitrary value.
	// A short bit time keeps each UART datagram near eight hundred cycles.
	localparam int          DIV     = 16;
	logic                   core_clk  = 1'b0;
	logic                   sys_rst   = 1'b1;
	logic [2:0]             regAddr   = 3'h0;
	logic [31:0]            regWrData = 32'h0;
	logic                   regWr     = 1'b0;
	logic                   regRd     = 1'b0;
	logic [31:0]            regRdData;
	logic [RT_WORDS*32-1:0] rtData    = {RT_WORDS{32'hc3a5_0f96}};
	logic [39:0]            mosiCap   = 40'h0;
	logic [39:0]            misoCap   = 40'h0;
	logic [31:0]            got;
	logic [31:0]            info [3]  = '{TYPE_ID, VER_ID, 32'h0};
	logic [31:0]            baud [4]  = '{BAUD_115200, BAUD_921600,
		BAUD_3M, BAUD_9600};
	int                     n_errors  = 0;
	int                     check_count = 0;
	sura_if link ();
	sura_host #(.HOST_BAUD_CYC(DIV)) u_sura_host (.core_clk(core_clk),
		.sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData(regRdData),
		.link(link.host));
	sura_device #(.CHIP_TYPE(TYPE_ID), .CHIP_VERSION(VER_ID),
		.TIMEOUT_CYC(20000), .DIV_9600_CYC(DIV)) u_sura_device (
		.core_clk(core_clk), .sys_rst(sys_rst), .rtData(rtData),
		.link(link.dev));
	sura_props #(.BAUD_CYC(DIV)) u_sura_props (.core_clk(core_clk),
		.sys_rst(sys_rst), .sck(link.sck), .chipSelectN(link.chipSelectN),
		.mosi(link.mosi), .misoOut(link.misoOut), .misoOe(link.misoOe),
		.hostTxd(link.hostTxd), .devTxd(link.devTxd));
	initial begin
		forever #10 core_clk = ~core_clk;
	end
	always @(posedge link.sck) begin
		if (!link.chipSelectN) begin
			mosiCap <= {mosiCap[38:0], link.mosi};
			misoCap <= {misoCap[38:0], link.miso};
		end
	end
	task automatic conclude;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : conclude
	task automatic chk(input logic [39:0] g, input logic [39:0] e);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value at %0t: got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [2:0] a, input logic [31:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge core_clk);
		regWr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a, output logic [31:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge core_clk);
		regRd <= 1'b0;
		#1 d = regRdData;
	endtask : rd
	task automatic go(input logic [1:0] m, input logic [39:0] dg);
		int i;
		wr(H_TXHI, {24'h0, dg[39:32]});
		wr(H_TXDATA, dg[31:0]);
		wr(H_CTRL, {30'h0, m});
		got = 32'h0;
		for (i = 0; i < 5000 && (got[3:2] & m) !== m; i++) begin
			rd(H_CTRL, got);
		end
		chk(40'(got[3:2] & m), 40'(m));
		wr(H_CTRL, {28'h0, m, 2'h0});
	endtask : go
	task automatic spi(input logic [39:0] dg, input logic [31:0] e);
		go(2'b01, dg);
		rd(H_SPIRX, got);
		chk(40'(got), 40'(e));
		chk(mosiCap, dg);
		chk(misoCap, {8'h00, e});
	endtask : spi
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge core_clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge core_clk);
		rd(3'h7, got);
		chk(40'(got), 40'h0);
		spi(40'h79_0000_0000, BAUD_RESET);
		for (int k = 0; k < 4; k++) begin
			spi({8'hf9, baud[k]}, k == 0 ? BAUD_RESET : baud[k - 1]);
		end
		spi(40'h79_0000_0000, BAUD_9600);
		$display("test baud done");
		spi(40'h80_ffff_ffff, TYPE_ID);
		for (int s = 1; s < 4; s++) begin
			spi({8'h81, 32'(s % 3)}, 32'((s - 1) % 3));
			spi(40'h00_0000_0000, info[s % 3]);
		end
		$display("test spi done");
		go(2'b10, 40'h81_0000_0001);
		go(2'b10, 40'h01_0000_0000);
		rd(H_UARTRX, got);
		chk(40'(got), 40'h1);
		rd(H_UARTHI, got);
		chk(40'(got[7:0]), 40'h01);
		$display("test uart done");
		go(2'b11, 40'h79_0000_0000);
		rd(H_UARTRX, got);
		chk(40'(got), 40'(BAUD_9600));
		rd(H_SPIRX, got);
		chk(40'(got), 40'(BAUD_9600));
		$display("test shared done");
		// The burst's second group of five holds the first monitoring bytes.
		go(2'b10, 40'h7f_0000_0000);
		rd(H_UARTHI, got);
		chk(40'(got[7:0]), 40'h7f);
		got = 32'h0;
		for (int i = 0; i < 5000 && got[3] !== 1'b1; i++)
			rd(H_CTRL, got);
		rd(H_UARTRX, got);
		chk(40'(got), 40'(rtData[RT_WORDS*32-9 -: 32]));
		$display("test burst done");
		conclude();
	end
	initial begin
		#1_500_000;
		n_errors++;
		conclude();
	end
endmodule : tb_top
